// file: core/dds_pkg.sv
/*
 * Shared constants for the phase-accumulating sine synthesizer and its
 * host-side loader: pipeline depths, link timing, host register map.
 * Assumes both ends run on one 20 MHz system clock.
 */
package dds_pkg;

    // ----------------------------------------------------------------
    // Clock and link timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int LINK_PERIOD_NS = 400;
    localparam int LINK_HALF_CYC = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
    localparam int RST_MIN_NS = 12;
    localparam int RST_HOLD_RAW = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RST_HOLD_CYC = (RST_HOLD_RAW < 1) ? 1 : RST_HOLD_RAW;
    localparam int SYNC_STAGES = 2;

    // ----------------------------------------------------------------
    // Datapath shape
    // ----------------------------------------------------------------
    localparam int WORD_W = 32;
    localparam int PHASE_W = 15;
    localparam int SAMPLE_W = 12;
    localparam int PRE_ALIGN_STAGES = 4;
    localparam int POST_FLUSH_CYC = 9;
    localparam int POST_ALIGN_STAGES = POST_FLUSH_CYC - 3;
    localparam int FILL_CYC = PRE_ALIGN_STAGES + 1 + POST_FLUSH_CYC;
    localparam logic [11:0] MIDSCALE = 12'h800;
    localparam logic [31:0] WORD_RESET = 32'h0000_0000;

    // Host waits, counted in its own cycles, include the pin synchroniser.
    localparam int PRE_WAIT_CYC = SYNC_STAGES + 2 + PRE_ALIGN_STAGES;
    localparam int POST_WAIT_CYC = SYNC_STAGES + 1 + POST_FLUSH_CYC;

    // ----------------------------------------------------------------
    // Host register map
    // ----------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CMD = 8'h04;
    localparam logic [7:0] OFS_WORD = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam int CTRL_PARALLEL = 0;
    localparam int CTRL_FORMAT = 1;
    localparam int CTRL_TOGGLE = 2;
    localparam int CTRL_CARRY = 3;
    localparam int CMD_LOAD = 0;
    localparam int CMD_XFER = 1;
    localparam int CMD_ZERO = 2;
    localparam logic [3:0] CTRL_RESET = 4'h1;

    typedef enum logic [2:0] {
        DDS_IDLE = 3'b000,
        DDS_LOAD = 3'b001,
        DDS_XFER = 3'b010,
        DDS_PRE_WAIT = 3'b011,
        DDS_RST = 3'b100,
        DDS_POST_WAIT = 3'b101
    } dds_state_t;

endpackage

// file: core/dds_link_if.sv
/*
 * Pin-level link between the host loader and the synthesizer core.
 * Assumes the bench joins both modports; no clock travels in it except
 * the host-made buffer load clock, which is a plain signal here.
 */
interface dds_link_if;
    logic buffer_load_clock; // Host-made load clock.
    logic buffer_load_enable; // Buffer capture enable.
    logic parallel_load_select; // High parallel, low serial.
    logic [31:0] tuning_word; // Word lines, bit 0 is the serial line.
    logic freq_word_transfer_enable; // Buffer to control register.
    logic phase_zero_reset_pin; // Synchronous phase clear.
    logic output_format_select; // High two's complement.
    logic carry_toggle_enable; // Internal alternating carry.
    logic accumulator_carry_in; // External carry.
    logic accumulator_carry_out; // Adder carry out.
    logic [11:0] sine_sample_out; // Sample word.
    logic sample_valid_strobe; // Sample valid level.

    modport host (
        output buffer_load_clock, buffer_load_enable, parallel_load_select, tuning_word,
        output freq_word_transfer_enable, phase_zero_reset_pin, output_format_select,
        output carry_toggle_enable, accumulator_carry_in,
        input accumulator_carry_out, sine_sample_out, sample_valid_strobe
    );
    modport device (
        input buffer_load_clock, buffer_load_enable, parallel_load_select, tuning_word,
        input freq_word_transfer_enable, phase_zero_reset_pin, output_format_select,
        input carry_toggle_enable, accumulator_carry_in,
        output accumulator_carry_out, sine_sample_out, sample_valid_strobe
    );
endinterface

// file: core/dds_synth.sv
/*
 * Synthesizer core: double-buffered tuning word, pipelined 32-bit phase
 * accumulator and quarter-wave sine converter with a registered output.
 * Assumes every link input is asynchronous and held stable for several
 * system clocks around each load clock edge.
 */
module dds_synth (
    input wire logic pclk, // System clock.
    input wire logic presetn, // Asynchronous reset, active low.
    input wire logic clk_en, // Freezes all state while low.
    dds_link_if.device link // Pin link to the host.
);
    import dds_pkg::*;

    // ----------------------------------------------------------------
    // Quarter-wave amplitude
    // ----------------------------------------------------------------
    // Parabolic fit x*(2-x) over one quadrant; cheap, and exact at the
    // zero crossings and peaks, which keeps the fold seamless.
    function automatic logic [10:0] quarter_amp(input logic [12:0] x);
        logic [27:0] prod;
        prod = {15'h0, x} * (28'h0004000 - {15'h0, x});
        return prod[25:15];
    endfunction

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    localparam int PIN_W = WORD_W + 8;
    logic [PIN_W-1:0] pin_meta;
    logic [PIN_W-1:0] pin_sync;
    wire [PIN_W-1:0] pin_raw = {link.buffer_load_clock, link.buffer_load_enable,
        link.parallel_load_select, link.freq_word_transfer_enable,
        link.phase_zero_reset_pin, link.output_format_select,
        link.carry_toggle_enable, link.accumulator_carry_in, link.tuning_word};

    // Every pin passes two flops; only the second stage is read below.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else if (clk_en) begin
            pin_meta <= pin_raw;
            pin_sync <= pin_meta;
        end
    end

    wire load_clk_s = pin_sync[WORD_W + 7];
    wire load_en_s = pin_sync[WORD_W + 6];
    wire parallel_s = pin_sync[WORD_W + 5];
    wire xfer_s = pin_sync[WORD_W + 4];
    wire zero_rst_s = pin_sync[WORD_W + 3];
    wire format_s = pin_sync[WORD_W + 2];
    wire toggle_s = pin_sync[WORD_W + 1];
    wire carry_in_s = pin_sync[WORD_W];
    wire [31:0] word_s = pin_sync[WORD_W-1:0];

    // ----------------------------------------------------------------
    // Double-buffered tuning word
    // ----------------------------------------------------------------
    logic load_clk_prev;
    logic [31:0] word_buffer;
    logic [31:0] freq_word;
    wire load_clk_rise = load_clk_s & ~load_clk_prev;
    // Serial data enters at bit 0 so the first bit sent ends up at bit 31.
    wire [31:0] serial_next = {word_buffer[30:0], word_s[0]};
    wire [31:0] buffer_next = parallel_s ? word_s : serial_next;

    // The load clock is sampled here, so the host may load at any moment
    // without touching the active control word.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            load_clk_prev <= 1'b0;
            word_buffer <= WORD_RESET;
        end else if (clk_en) begin
            load_clk_prev <= load_clk_s;
            if (load_clk_rise && load_en_s) begin
                word_buffer <= buffer_next;
            end
        end
    end

    // Transfer on every clock edge at which the enable is seen high.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            freq_word <= WORD_RESET;
        end else if (clk_en && xfer_s) begin
            freq_word <= word_buffer;
        end
    end

    // ----------------------------------------------------------------
    // Pre-adder alignment
    // ----------------------------------------------------------------
    logic [31:0] pre_align [PRE_ALIGN_STAGES];

    // These stages are deliberately untouched by the phase reset, which is
    // why the host must flush them with a zero word first.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < PRE_ALIGN_STAGES; i++) begin
                pre_align[i] <= WORD_RESET;
            end
        end else if (clk_en) begin
            pre_align[0] <= freq_word;
            for (int i = 1; i < PRE_ALIGN_STAGES; i++) begin
                pre_align[i] <= pre_align[i-1];
            end
        end
    end

    // ----------------------------------------------------------------
    // Phase accumulator
    // ----------------------------------------------------------------
    logic [31:0] phase_acc;
    logic carry_toggle;
    logic carry_out;
    wire carry_bit = toggle_s ? carry_toggle : carry_in_s;
    wire [32:0] phase_sum = {1'b0, phase_acc} + {1'b0, pre_align[PRE_ALIGN_STAGES-1]}
        + {32'h0000_0000, carry_bit};

    // The toggle runs every cycle so successive sums alternate their carry.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            carry_toggle <= 1'b0;
            phase_acc <= WORD_RESET;
            carry_out <= 1'b0;
        end else if (clk_en) begin
            carry_toggle <= ~carry_toggle;
            carry_out <= phase_sum[32];
            if (zero_rst_s) begin
                phase_acc <= WORD_RESET;
            end else begin
                phase_acc <= phase_sum[31:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Post-adder alignment
    // ----------------------------------------------------------------
    logic [PHASE_W-1:0] post_align [POST_ALIGN_STAGES];

    // Only the top phase bits travel on; the rest do not affect amplitude.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < POST_ALIGN_STAGES; i++) begin
                post_align[i] <= '0;
            end
        end else if (clk_en) begin
            post_align[0] <= phase_acc[31:32-PHASE_W];
            for (int i = 1; i < POST_ALIGN_STAGES; i++) begin
                post_align[i] <= post_align[i-1];
            end
        end
    end

    // ----------------------------------------------------------------
    // Sine conversion
    // ----------------------------------------------------------------
    logic [PHASE_W-1:0] phase_tail;
    logic [12:0] fold_index;
    logic fold_neg;
    logic [10:0] amp;
    logic amp_neg;
    logic [11:0] sample;
    logic [11:0] sample_next;
    logic [4:0] fill_cnt;
    logic sample_valid;

    assign phase_tail = post_align[POST_ALIGN_STAGES-1];
    // Odd quadrants run the quarter wave backwards; upper half is negative.
    wire [12:0] index_next = phase_tail[13] ? ~phase_tail[12:0] : phase_tail[12:0];
    wire [11:0] unsigned_sample = amp_neg ? (MIDSCALE - {1'b0, amp})
        : (MIDSCALE + {1'b0, amp});
    wire [11:0] twos_sample = {~unsigned_sample[11], unsigned_sample[10:0]};

    always_comb begin
        sample_next = format_s ? twos_sample : unsigned_sample;
    end

    // Fold, amplitude and output stages close the nine-cycle tail.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fold_index <= '0;
            fold_neg <= 1'b0;
            amp <= '0;
            amp_neg <= 1'b0;
            sample <= MIDSCALE;
        end else if (clk_en) begin
            fold_index <= index_next;
            fold_neg <= phase_tail[14];
            amp <= quarter_amp(fold_index);
            amp_neg <= fold_neg;
            sample <= sample_next;
        end
    end

    // ----------------------------------------------------------------
    // Sample valid strobe
    // ----------------------------------------------------------------
    // Held low until the whole pipeline carries post-reset data; the level
    // then stays high and samples may be taken on every system clock edge.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fill_cnt <= '0;
            sample_valid <= 1'b0;
        end else if (clk_en) begin
            if (fill_cnt != 5'(FILL_CYC)) begin
                fill_cnt <= fill_cnt + 5'h01;
            end
            sample_valid <= (fill_cnt == 5'(FILL_CYC));
        end
    end

    assign link.sine_sample_out = sample;
    assign link.sample_valid_strobe = sample_valid;
    assign link.accumulator_carry_out = carry_out;

endmodule

// file: core/dds_host.sv
/*
 * Host loader: an APB slave whose registers drive the synthesizer pins,
 * make the load clock by division, run the zero-phase sequence and catch
 * the latest sample. Assumes zero-wait APB masters and one system clock.
 */
// Local design decisions: register access over APB and the register addresses.
module dds_host (
    input wire logic pclk, // System clock.
    input wire logic presetn, // Asynchronous reset, active low.
    input wire logic clk_en, // Freezes all state while low.
    input wire logic psel, // APB select.
    input wire logic penable, // APB access phase.
    input wire logic pwrite, // APB direction.
    input wire logic [dds_pkg::ADDR_W-1:0] paddr, // APB byte address.
    input wire logic [31:0] pwdata, // APB write data.
    output logic [31:0] prdata, // APB read data.
    output logic pready, // APB ready.
    output logic pslverr, // APB error on unmapped address.
    dds_link_if.host link // Pin link to the synthesizer.
);
    import dds_pkg::*;

    // ----------------------------------------------------------------
    // APB decode and registers
    // ----------------------------------------------------------------
    dds_state_t state;
    logic [3:0] ctrl;
    logic [31:0] word;
    logic [11:0] last_sample;
    logic [2:0] in_meta;
    logic [2:0] in_sync;
    logic [11:0] smp_meta;
    logic [11:0] smp_sync;
    wire busy = (state != DDS_IDLE);
    wire setup = psel & ~penable & ~pready;
    wire commit = psel & penable & pready;
    wire hit_ctrl = (paddr == OFS_CTRL);
    wire hit_cmd = (paddr == OFS_CMD);
    wire hit_word = (paddr == OFS_WORD);
    wire hit_status = (paddr == OFS_STATUS);
    wire mapped = hit_ctrl | hit_cmd | hit_word | hit_status;
    wire [31:0] status_word = {4'h0, last_sample, 13'h0, in_sync[0], in_sync[2], busy};
    wire [31:0] read_mux = hit_ctrl ? {28'h0000000, ctrl} : hit_word ? word
        : hit_status ? status_word : 32'h0000_0000;
    wire cmd_wr = commit & pwrite & hit_cmd & ~busy;

    // One wait-free access: ready and data are registered in the setup cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= '0;
            pslverr <= 1'b0;
            ctrl <= CTRL_RESET;
            word <= WORD_RESET;
        end else if (clk_en) begin
            pready <= setup;
            pslverr <= setup & ~mapped;
            prdata <= (setup & ~pwrite) ? read_mux : 32'h0000_0000;
            if (commit && pwrite && hit_ctrl) begin
                ctrl <= pwdata[3:0];
            end
            if (commit && pwrite && hit_word && !busy) begin
                word <= pwdata;
            end
        end
    end

    // ----------------------------------------------------------------
    // Return path from the synthesizer
    // ----------------------------------------------------------------
    // Receiver runs on the system clock; the strobe is only a valid level.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_meta <= '0;
            in_sync <= '0;
            smp_meta <= '0;
            smp_sync <= '0;
            last_sample <= '0;
        end else if (clk_en) begin
            in_meta <= {link.sample_valid_strobe, 1'b0, link.accumulator_carry_out};
            in_sync <= in_meta;
            smp_meta <= link.sine_sample_out;
            smp_sync <= smp_meta;
            if (in_sync[2]) begin
                last_sample <= smp_sync;
            end
        end
    end

    // ----------------------------------------------------------------
    // Load sequencer
    // ----------------------------------------------------------------
    logic [7:0] cnt;
    logic [5:0] bits_left;
    logic [31:0] shifter;
    logic zero_seq;
    logic load_clk;
    logic load_en;
    logic [31:0] tw;
    logic xfer;
    logic zrst;
    wire half_done = (cnt == 8'(LINK_HALF_CYC - 1));
    wire last_bit = (bits_left == 6'h01);
    wire [31:0] first_out = ctrl[CTRL_PARALLEL] ? shifter : {31'h0, shifter[31]};

    // Word lines change only while the load clock is low, three system clocks
    // ahead of its rising edge, so the core's sampled copy is settled.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= DDS_IDLE;
            cnt <= '0;
            bits_left <= '0;
            shifter <= WORD_RESET;
            zero_seq <= 1'b0;
            load_clk <= 1'b0;
            load_en <= 1'b0;
            tw <= WORD_RESET;
            xfer <= 1'b0;
            zrst <= 1'b0;
        end else if (clk_en) begin
            xfer <= (state == DDS_XFER);
            zrst <= (state == DDS_RST);
            cnt <= cnt + 8'h01;
            unique case (state)
                DDS_IDLE: begin
                    cnt <= '0;
                    if (cmd_wr && (pwdata[CMD_LOAD] || pwdata[CMD_ZERO])) begin
                        state <= DDS_LOAD;
                        zero_seq <= pwdata[CMD_ZERO];
                        shifter <= pwdata[CMD_ZERO] ? WORD_RESET : word;
                        bits_left <= ctrl[CTRL_PARALLEL] ? 6'h01 : 6'h20;
                    end else if (cmd_wr && pwdata[CMD_XFER]) begin
                        state <= DDS_XFER;
                        zero_seq <= 1'b0;
                    end
                end
                DDS_LOAD: begin
                    load_en <= 1'b1;
                    if (cnt == 8'h00 && !load_clk) begin
                        tw <= first_out;
                    end
                    if (half_done) begin
                        cnt <= '0;
                        load_clk <= ~load_clk;
                        if (load_clk) begin
                            bits_left <= bits_left - 6'h01;
                            shifter <= {shifter[30:0], 1'b0};
                            if (last_bit) begin
                                load_en <= 1'b0;
                                state <= zero_seq ? DDS_XFER : DDS_IDLE;
                            end
                        end
                    end
                end
                DDS_XFER: begin
                    cnt <= '0;
                    state <= zero_seq ? DDS_PRE_WAIT : DDS_IDLE;
                end
                DDS_PRE_WAIT: begin
                    if (cnt == 8'(PRE_WAIT_CYC - 1)) begin
                        cnt <= '0;
                        state <= DDS_RST;
                    end
                end
                DDS_RST: begin
                    if (cnt == 8'(RST_HOLD_CYC - 1)) begin
                        cnt <= '0;
                        state <= DDS_POST_WAIT;
                    end
                end
                DDS_POST_WAIT: begin
                    if (cnt == 8'(POST_WAIT_CYC - 1)) begin
                        state <= DDS_IDLE;
                        zero_seq <= 1'b0;
                    end
                end
                default: begin
                    state <= DDS_IDLE;
                end
            endcase
        end
    end

    assign link.buffer_load_clock = load_clk;
    assign link.buffer_load_enable = load_en;
    assign link.parallel_load_select = ctrl[CTRL_PARALLEL];
    assign link.tuning_word = tw;
    assign link.freq_word_transfer_enable = xfer;
    assign link.phase_zero_reset_pin = zrst;
    assign link.output_format_select = ctrl[CTRL_FORMAT];
    assign link.carry_toggle_enable = ctrl[CTRL_TOGGLE];
    assign link.accumulator_carry_in = ctrl[CTRL_CARRY];

endmodule

// file: sim/dds_link_asserts.sv
/* Checker on the link between the loader and the synthesizer.
   Assumes one system clock and clk_en held high by the bench. */
module dds_link_asserts (
    input wire logic pclk, // System clock.
    input wire logic presetn, // Reset, active low.
    input wire logic buffer_load_clock, // Load clock.
    input wire logic buffer_load_enable, // Load enable.
    input wire logic [31:0] tuning_word, // Word lines.
    input wire logic freq_word_transfer_enable, // Transfer pulse.
    input wire logic phase_zero_reset_pin, // Phase clear.
    input wire logic output_format_select, // Sample format.
    input wire logic [11:0] sine_sample_out, // Sample.
    input wire logic sample_valid_strobe // Valid level.
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Link properties, one clock domain.
    // ----------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // The load clock high phase is four system clocks of its 400 ns period.
    load_clk_pulse_a: assert property ($rose(buffer_load_clock) |->
        buffer_load_clock [*4] ##1 !buffer_load_clock) else $error("load clock phase");
    load_enabled_a: assert property (buffer_load_clock |-> buffer_load_enable)
        else $error("load clock without enable");
    word_stable_a: assert property (buffer_load_clock |-> $stable(tuning_word))
        else $error("word moved under load clock");
    xfer_pulse_a: assert property (freq_word_transfer_enable |=>
        !freq_word_transfer_enable) else $error("transfer pulse too long");
    flush_gap_a: assert property ($rose(freq_word_transfer_enable) |->
        !phase_zero_reset_pin [*5]) else $error("phase clear too soon");
    zero_word_a: assert property (phase_zero_reset_pin |-> tuning_word == 32'h0000_0000)
        else $error("phase clear with nonzero word");
    // Zero phase must reach the pins once the post stages have flushed.
    zero_out_a: assert property ($rose(phase_zero_reset_pin) |-> ##16
        sine_sample_out == (output_format_select ? 12'h000 : 12'h800))
        else $error("zero phase not at output");
    mid_fill_a: assert property (!sample_valid_strobe |-> sine_sample_out == 12'h800)
        else $error("sample left midscale while filling");
    strobe_hold_a: assert property (sample_valid_strobe |=> sample_valid_strobe)
        else $error("valid strobe dropped");
endmodule

// file: sim/dds_phase_sine_core_tb.sv
/* Bench joining loader and synthesizer, driven over APB.
   Assumes the loader answers each access within a bounded wait. */
module dds_phase_sine_core_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import dds_pkg::*;
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready;
    logic pslverr;
    logic er;
    int errors = 0;
    int checks_done = 0;
    int n;
    dds_link_if link ();
    // Clock, instances and checker.
    always #(CLK_PERIOD_NS / 2) pclk = ~pclk;
    dds_synth dds_synth_inst (.pclk(pclk), .presetn(presetn), .clk_en(1'h1), .link(link.device));
    dds_host dds_host_inst (.pclk(pclk), .presetn(presetn), .clk_en(1'h1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .link(link.host));
    dds_link_asserts dds_link_asserts_inst (.pclk(pclk), .presetn(presetn),
        .buffer_load_clock(link.buffer_load_clock), .buffer_load_enable(link.buffer_load_enable),
        .tuning_word(link.tuning_word), .freq_word_transfer_enable(link.freq_word_transfer_enable),
        .phase_zero_reset_pin(link.phase_zero_reset_pin),
        .output_format_select(link.output_format_select),
        .sine_sample_out(link.sine_sample_out), .sample_valid_strobe(link.sample_valid_strobe));
    // ----------------------------------------
    // Tasks.
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One APB transfer; the request holds until pready is seen high.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic idle();
        n = 0;
        do begin
            apb(1'h0, OFS_STATUS, 32'h0);
            n++;
        end while (rd[0] !== 1'h0 && n < 200);
        check(rd[0], 1'h0, "busy");
    endtask
    // Quarter-turn word: samples step peak, midscale, trough once it lands.
    task automatic run(input logic [11:0] pk, input logic [11:0] tr, input logic [11:0] mid);
        apb(1'h1, OFS_WORD, 32'h4000_0000);
        apb(1'h1, OFS_CMD, 32'h1);
        idle();
        apb(1'h1, OFS_CMD, 32'h2);
        n = 0;
        while (link.freq_word_transfer_enable !== 1'h1 && n < 50) begin
            @(posedge pclk);
            n++;
        end
        check(link.freq_word_transfer_enable, 1'h1, "transfer");
        n = 0;
        while (link.sine_sample_out === mid && n < 60) begin
            @(posedge pclk);
            n++;
        end
        check(32'(n >= 16), 32'h1, "midscale hold");
        check(link.sine_sample_out, pk, "peak");
        repeat (2) @(posedge pclk);
        check(link.sine_sample_out, tr, "trough");
    endtask
    task automatic print_verdict();
        if (errors == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Main sequence, then a watchdog against hangs.
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        check(link.sine_sample_out, 12'h800, "fill");
        apb(1'h0, OFS_CTRL, 32'h0);
        check(rd, 32'h1, "ctrl reset");
        apb(1'h0, 8'h10, 32'h0);
        check(er, 1'h1, "unmapped");
        run(12'hFFF, 12'h001, 12'h800);
        apb(1'h0, OFS_STATUS, 32'h0);
        check(rd[1], 1'h1, "valid");
        apb(1'h1, OFS_CTRL, 32'h2);
        apb(1'h1, OFS_CMD, 32'h4);
        idle();
        repeat (4) @(posedge pclk);
        check(link.sine_sample_out, 12'h000, "zero phase");
        apb(1'h0, OFS_STATUS, 32'h0);
        check(rd[27:16], 12'h000, "last sample");
        check(rd[2:1], 2'h1, "carry and valid");
        run(12'h7FF, 12'h801, 12'h000);
        print_verdict();
    end
    initial begin
        #400000;
        errors++;
        print_verdict();
    end
endmodule
